// ### verilog/sds_serdes_top.sv
// four-bit serializer and deserializer with word slip
//
// Contract
// RULE1 - serial output shifts on the bit clock
// RULE2 - one 4-bit word sent per word period
// RULE3 - word clock is bit clock divided by four
// RULE4 - feeder times words from serializer word clock
// RULE5 - deserializer presents one 4-bit word per period
// RULE6 - serial input sampled on the bit clock
// RULE7 - receive word clock in step with words
// RULE8 - slip input moves the word boundary
// RULE9 - slip falling edge: data invalid twelve bits
// RULE10 - slip high and low held minimum width
// RULE11 - bit 0 sent first, received first
// RULE12 - each slip moves boundary one bit
module sds_serdes_top
   import sds_pkg::*;
(
   input  wire logic              CLK,
   input  wire logic              SRST,
   input  wire logic [WORD_W-1:0] TX_WORD,
   input  wire logic              TX_VALID,
   output logic                   TX_READY,
   output logic                   SERIAL_LINE_POS,
   output logic                   TX_WORD_CLOCK_OUT_POS,
   input  wire logic              RX_SERIAL_LINE_POS,
   input  wire logic              WORD_SLIP,
   output logic      [WORD_W-1:0] RX_WORD,
   output logic                   RX_VALID,
   output logic                   RX_WORD_CLOCK_OUT_POS
);
   // transmit side state
   logic [1:0]        tx_cnt_reg;                           // bit slot within word
   logic [1:0]        tx_cnt_next;
   logic [WORD_W-1:0] tx_shift_reg;                         // word being shifted out
   logic [WORD_W-1:0] tx_shift_next;
   logic              tx_serial_reg;                        // serial line flop
   logic              tx_wclk_reg;                          // transmit word clock
   logic              buf_ready;                            // buffer accepts a word
   logic              buf_valid;                            // buffer holds a word
   logic [WORD_W-1:0] buf_word;                             // oldest buffered word

   // receive side state
   logic [1:0]        rx_cnt_reg;                           // bit slot within word
   logic [1:0]        rx_cnt_next;
   logic [WORD_W-1:0] rx_shift_reg;                         // incoming bits
   logic [WORD_W-1:0] rx_word_reg;                          // presented word
   logic              rx_valid_reg;                         // presented word good
   logic              rx_wclk_reg;                          // receive word clock
   logic              slip_prev_reg;                        // slip level last cycle
   logic [3:0]        rx_inval_reg;                         // bits left in invalid window
   logic [3:0]        rx_inval_next;

   // decode
   wire               tx_load   = (tx_cnt_reg == BIT_LAST);              // take next word
   wire               buf_take  = tx_load && buf_valid;                  // buffer drained
   wire               slip_fall = slip_prev_reg && !WORD_SLIP;           // slip falling edge
   wire               rx_done   = (rx_cnt_reg == BIT_LAST) && !slip_fall; // word complete
   wire [WORD_W-1:0]  rx_assembled = {RX_SERIAL_LINE_POS, rx_shift_reg[WORD_W-1:1]};

   // feeder words are held here until the serializer slot comes round
   sds_word_buf #(
      .WIDTH (WORD_W),
      .DEPTH (BUF_DEPTH)
   ) u_tx_buf (
      .clk       (CLK),
      .srst      (SRST),
      .in_data   (TX_WORD),
      .in_valid  (TX_VALID),
      .in_ready  (buf_ready),
      .out_valid (buf_valid),
      .out_data  (buf_word),
      .out_ready (tx_load)                                   // [RULE4]
   );

   // serializer next-state
   assign tx_cnt_next   = tx_load ? BIT_FIRST : tx_cnt_reg + 2'(1);             // [RULE3]
   assign tx_shift_next = tx_load ? (buf_valid ? buf_word : WORD_IDLE)          // [RULE2]
                                  : {1'b0, tx_shift_reg[WORD_W-1:1]};           // [RULE11]

   // deserializer next-state; a slip edge holds the slot one bit
   assign rx_cnt_next   = slip_fall ? rx_cnt_reg                                // [RULE12]
                        : (rx_cnt_reg == BIT_LAST) ? BIT_FIRST : rx_cnt_reg + 2'(1);
   assign rx_inval_next = slip_fall ? SLIP_INVALID_BITS                         // [RULE9]
                        : (rx_inval_reg != INVAL_NONE) ? rx_inval_reg - INVAL_STEP : INVAL_NONE;

   // serializer registers, shift on every bit clock
   always_ff @(posedge CLK) begin
      if (SRST) begin
         tx_cnt_reg    <= BIT_FIRST;
         tx_shift_reg  <= WORD_IDLE;
         tx_serial_reg <= 1'b0;
         tx_wclk_reg   <= 1'b0;
      end else begin
         tx_cnt_reg    <= tx_cnt_next;
         tx_shift_reg  <= tx_shift_next;
         tx_serial_reg <= tx_shift_reg[0];                    // [RULE1]
         tx_wclk_reg   <= (tx_cnt_next < WCLK_HIGH_SLOTS);     // [RULE3]
      end
   end

   // deserializer registers, sample on every bit clock
   always_ff @(posedge CLK) begin
      if (SRST) begin
         rx_cnt_reg    <= BIT_FIRST;
         rx_shift_reg  <= WORD_IDLE;
         rx_word_reg   <= WORD_IDLE;
         rx_valid_reg  <= 1'b0;
         rx_wclk_reg   <= 1'b0;
         slip_prev_reg <= 1'b0;
         rx_inval_reg  <= INVAL_NONE;
      end else begin
         rx_cnt_reg    <= rx_cnt_next;
         rx_shift_reg  <= rx_assembled;                        // [RULE6]
         slip_prev_reg <= WORD_SLIP;                           // [RULE8]
         rx_inval_reg  <= rx_inval_next;
         rx_wclk_reg   <= (rx_cnt_next < WCLK_HIGH_SLOTS);     // [RULE7]
         rx_valid_reg  <= rx_done && (rx_inval_reg == INVAL_NONE) && !slip_fall; // [RULE9]
         if (rx_done) begin
            rx_word_reg <= rx_assembled;                       // [RULE5] [RULE11]
         end
      end
   end

   // outputs straight from flops
   assign TX_READY              = buf_ready;
   assign SERIAL_LINE_POS       = tx_serial_reg;
   assign TX_WORD_CLOCK_OUT_POS = tx_wclk_reg;
   assign RX_WORD               = rx_word_reg;
   assign RX_VALID              = rx_valid_reg;
   assign RX_WORD_CLOCK_OUT_POS = rx_wclk_reg;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   // four bits of a taken word leave bit 0 first
   sequence tx_bits_s(logic [WORD_W-1:0] w);
      ##2 SERIAL_LINE_POS == w[0] ##1 SERIAL_LINE_POS == w[1]
      ##1 SERIAL_LINE_POS == w[2] ##1 SERIAL_LINE_POS == w[3];
   endsequence
   property tx_order_p;
      logic [WORD_W-1:0] w;
      (buf_take, w = buf_word) |-> tx_bits_s(w);
   endproperty
   tx_order_a: assert property (tx_order_p)                  // [RULE11] [RULE1]
      else $error("serial bits out of order");

   tx_take_a: assert property (buf_take |=> !$past(tx_load, 2) && tx_cnt_reg == BIT_FIRST) // [RULE2]
      else $error("buffer drained outside word slot");

   // the first high phase after reset is one slot short, so periods count from slot 0
   tx_wclk_a: assert property ($rose(TX_WORD_CLOCK_OUT_POS) && tx_cnt_reg == BIT_FIRST // [RULE3]
                               |-> ##4 $rose(TX_WORD_CLOCK_OUT_POS))
      else $error("transmit word clock not divide by four");

   // every completed word raises the receive word clock with it
   rx_wclk_a: assert property (rx_done |=> $rose(RX_WORD_CLOCK_OUT_POS) && rx_cnt_reg == BIT_FIRST) // [RULE7]
      else $error("receive word clock not aligned to word update");

   rx_word_a: assert property (rx_done |=> RX_WORD == {$past(RX_SERIAL_LINE_POS, 1), $past(RX_SERIAL_LINE_POS, 2),
                                                      $past(RX_SERIAL_LINE_POS, 3), $past(RX_SERIAL_LINE_POS, 4)}) // [RULE5]
      else $error("received word bits misplaced");

   slip_step_a: assert property (slip_fall |=> rx_cnt_reg == $past(rx_cnt_reg)) // [RULE12] [RULE8]
      else $error("slip did not hold boundary one bit");

   slip_quiet_a: assert property (slip_fall |=> !RX_VALID [*8] ##1 !RX_VALID [*4]) // [RULE9]
      else $error("data valid inside slip window");

   rx_valid_a: assert property (rx_done && rx_inval_reg == INVAL_NONE |=> RX_VALID) // [RULE5]
      else $error("complete word not flagged valid");
endmodule : sds_serdes_top

// ### pkg/sds_pkg.sv
// shared constants for the four-bit serializer / deserializer pair
package sds_pkg;
   localparam int         WORD_W             = 4;                    // parallel word width
   localparam int         CLK_DIV            = 4;                    // bit clock to word clock ratio
   localparam int         BUF_DEPTH          = 2;                    // entries in the transmit buffer
   localparam logic [1:0] BIT_FIRST          = 2'h0;                 // first bit slot of a word
   localparam logic [1:0] BIT_LAST           = 2'h3;                 // last bit slot of a word
   localparam logic [1:0] WCLK_HIGH_SLOTS    = 2'h2;                 // word clock high in slots below this
   localparam int         SLIP_INVALID_WORDS = 3;                    // word periods of invalid data after slip
   localparam logic [3:0] SLIP_INVALID_BITS  = 4'(SLIP_INVALID_WORDS * CLK_DIV); // same, in bit periods
   localparam logic [3:0] INVAL_NONE         = 4'h0;                 // invalid window over
   localparam logic [3:0] INVAL_STEP         = 4'h1;                 // invalid window decrement
   localparam logic [WORD_W-1:0] WORD_IDLE   = 4'h0;                 // word sent while no data waits
   localparam int         CLK_PERIOD_PS      = 20000;                // bit clock period, 50 MHz
   localparam int         SLIP_MIN_PW_PS     = 2000;                 // least slip high or low time
   localparam int         SLIP_MIN_PW_CYC    = (SLIP_MIN_PW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1 ? 1 :
                                               (SLIP_MIN_PW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage : sds_pkg

// ### verilog/sds_word_buf.sv
// two-entry word buffer with valid and ready on both sides
module sds_word_buf #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 2
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;     // pointer width
   localparam int CW = $clog2(DEPTH + 1);                   // occupancy width

   logic [WIDTH-1:0] mem [DEPTH];                           // storage
   logic [AW-1:0]    wr_ptr_reg;                            // next slot written
   logic [AW-1:0]    rd_ptr_reg;                            // oldest slot
   logic [CW-1:0]    count_reg;                             // words held
   logic [CW-1:0]    count_next;                            // words held next cycle
   logic             in_ready_reg;                          // not full, registered
   logic             out_valid_reg;                         // not empty, registered
   wire              push = in_valid && in_ready_reg;       // word accepted
   wire              pop  = out_valid_reg && out_ready;     // word drained

   assign count_next = count_reg + CW'(push) - CW'(pop);
   assign in_ready   = in_ready_reg;
   assign out_valid  = out_valid_reg;
   assign out_data   = mem[rd_ptr_reg];

   // pointer advance with wrap at the depth
   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction : bump

   // storage write, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // pointers and honest full / empty flags
   always_ff @(posedge clk) begin
      if (srst) begin
         wr_ptr_reg    <= '0;
         rd_ptr_reg    <= '0;
         count_reg     <= '0;
         in_ready_reg  <= 1'b0;
         out_valid_reg <= 1'b0;
      end else begin
         if (push) wr_ptr_reg <= bump(wr_ptr_reg);
         if (pop)  rd_ptr_reg <= bump(rd_ptr_reg);
         count_reg     <= count_next;
         in_ready_reg  <= (count_next != CW'(DEPTH));
         out_valid_reg <= (count_next != '0);
      end
   end
endmodule : sds_word_buf

// ### tb/sds_line_peer.sv
// serial line peer: repeats one word, bit 0 first
module sds_line_peer
   import sds_pkg::*;
(
   input  wire logic              clk,
   input  wire logic [WORD_W-1:0] word,
   output logic                   line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0]        slot_reg = 2'h0; // bit slot within word
   logic [WORD_W-1:0] cur_reg  = 4'h0; // word on the line
   // new word taken only at a boundary, so words go whole
   always @(negedge clk) begin
      if (slot_reg == BIT_LAST) cur_reg <= word;
      slot_reg <= slot_reg + 2'h1;
   end
   assign line = cur_reg[slot_reg]; // first bit is bit 0
endmodule : sds_line_peer

// ### tb/test_four_bit_serdes_word_align.sv
// self-checking bench for the serializer / deserializer pair
module test_four_bit_serdes_word_align
   import sds_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk, srst, tx_valid, tx_ready, ser, tx_wclk; // clock, reset, tx side
   logic              rx_line, slip, rx_valid, rx_wclk;          // rx side
   logic [WORD_W-1:0] tx_word, rx_word, peer_word, txw;         // words
   logic [WORD_W-1:0] txq[$];                                    // words seen on the line
   int                fails = 0, n_checks = 0, txc = 4;          // counters, bit index
   logic              wprev = 1'b0;                              // last word clock

   sds_serdes_top uut (.CLK(clk), .SRST(srst), .TX_WORD(tx_word), .TX_VALID(tx_valid),
      .TX_READY(tx_ready), .SERIAL_LINE_POS(ser), .TX_WORD_CLOCK_OUT_POS(tx_wclk),
      .RX_SERIAL_LINE_POS(rx_line), .WORD_SLIP(slip), .RX_WORD(rx_word),
      .RX_VALID(rx_valid), .RX_WORD_CLOCK_OUT_POS(rx_wclk));
   sds_line_peer peer (.clk(clk), .word(peer_word), .line(rx_line));

   // free-running bit clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // gathers four line bits after each word clock rise
   always @(negedge clk) begin
      if (txc < 4) begin
         txw[txc] = ser;
         txc++;
         if (txc == 4 && txw != 4'h0) txq.push_back(txw);
      end
      if (tx_wclk && !wprev) txc = 0;
      wprev = tx_wclk;
   end
   // compare and count
   task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // both word clocks over eight bit periods
   task automatic test_clocks;
      logic [3:0] hi_t, up_t, hi_r, up_r, vr;
      logic       tp, rp; // word clocks one sample back
      {hi_t, up_t, hi_r, up_r, vr} = '0;
      tp = tx_wclk;
      rp = rx_wclk;
      repeat (8) begin
         @(negedge clk);
         hi_t += 4'(tx_wclk);
         hi_r += 4'(rx_wclk);
         up_t += 4'(tx_wclk && !tp);
         up_r += 4'(rx_wclk && !rp);
         vr   += 4'(rx_valid && rx_wclk);
         tp = tx_wclk;
         rp = rx_wclk;
      end
      chk(hi_t, 4'h4); // divide by four
      chk(up_t, 4'h2);
      chk(hi_r, 4'h4);
      chk(up_r, 4'h2);
      chk(vr, 4'h2);   // one word per period, with its clock
   endtask : test_clocks
   // offer a word and hold it until taken
   task automatic send(input logic [WORD_W-1:0] w, inout int waits);
      tx_word = w;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1 && waits < 100) begin
         waits++;
         @(negedge clk);
      end
      @(negedge clk);
   endtask : send
   // back-to-back words fill the buffer, then leave in order
   task automatic test_tx;
      logic [WORD_W-1:0] w[6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hB, 4'hE};
      int waits = 0;
      txq.delete();
      while (tx_wclk !== 1'b1) @(negedge clk); // first word timed from the word clock
      foreach (w[i]) send(w[i], waits);
      tx_valid = 1'b0;
      repeat (30) @(negedge clk);
      chk(4'(waits > 0 && waits < 100), 4'h1); // buffer refused while full
      chk(4'(txq.size()), 4'h6);                // no word lost or doubled
      foreach (w[i]) chk(txq[i], w[i]);         // bit 0 first, in order
   endtask : test_tx
   // next flagged word, bounded wait
   task automatic get_word(output logic [WORD_W-1:0] w);
      int n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (rx_valid !== 1'b1 && n < 40);
      chk(4'(n < 40), 4'h1);
      w = rx_word;
   endtask : get_word
   // one slip pulse, output unflagged for twelve bit periods after its fall
   task automatic do_slip;
      logic [3:0] seen = 4'h0;
      slip = 1'b1;
      repeat (2) @(negedge clk); // held high long enough
      slip = 1'b0;
      repeat (12) begin // twelve bit periods after the slip edge
         @(negedge clk);
         seen += 4'(rx_valid);
      end
      chk(seen, 4'h0); // invalid window
   endtask : do_slip
   // align by slips, rotate once per slip, then bit order
   task automatic test_rx;
      logic [WORD_W-1:0] w, w0;
      int k;
      get_word(w);
      for (k = 0; k < 4 && w !== 4'h1; k++) begin
         do_slip();
         get_word(w);
      end
      chk(w, 4'h1); // boundary reachable by slips
      for (k = 0; k < 4; k++) begin
         w0 = w;
         do_slip();
         get_word(w);
         chk(w, {w0[0], w0[3:1]}); // one bit per slip, wraps
      end
      peer_word = 4'h6;
      k = 0;
      do get_word(w); while (w === 4'h1 && k++ < 6);
      chk(w, 4'h6); // first bit on bit 0
   endtask : test_rx
   // counts and verdict
   task automatic final_report;
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   // hang guard, far beyond the expected run
   initial begin
      #200000;
      fails++;
      final_report();
   end
   // main sequence
   initial begin
      srst = 1'b1;
      tx_valid = 1'b0;
      tx_word = 4'h0;
      slip = 1'b0;
      peer_word = 4'h1;
      repeat (20) @(negedge clk);
      chk({tx_ready, tx_wclk, rx_valid, rx_wclk}, 4'h0); // quiet in reset
      chk(rx_word, 4'h0);
      srst = 1'b0;
      repeat (2) @(negedge clk);
      chk({3'h0, tx_ready}, 4'h1); // room after reset
      test_clocks();
      test_tx();
      test_rx();
      final_report();
   end
endmodule : test_four_bit_serdes_word_align
